/* led_breathing_blinking_pwm.v */
// led breathing/blinking pwm generator with axi4-lite register slave
//
// How it works
// - size select picks 8, 7 or 6 bit counter
// - 8-bit size counts 0..255, period ~7.8ms
// - 7-bit size counts 0..127, period ~3.9ms
// - 6-bit size counts 0..63, period ~1.95ms
// - led on while counter below duty cycle
// - off or reset bit clears all working state
// - breathing adds segment step at delay counter pace
// - at upper limit hold top time, then fall
// - at lower limit hold bottom time, then rise
// - hold times counted in duty-update ticks
// - symmetric mode: segment from duty bits 7:5
// - asymmetric: segment is falling flag, duty 7:6
// - segment k uses nibble 4k+3:4k
// - blinking: delay counter on slow or system clock
// - blinking reloads prescale; zero passes clock directly
// - blinking counter always 8-bit, size ignored
// - blink frequency is clock/(256*(prescale+1))
// - blink duty from lower limit; 00h off
// - output mode 3 forces led on
// - breathing-only settings ignored while blinking
// - one update tick equals one pwm period
// - limits take effect at period end
// - delay/step/interval copy at period end if enabled
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "led_pwm_map.vh"

module led_breathing_blinking_pwm (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        slow_tick,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         led_out
);

    // breathing states, one-hot
    localparam [3:0] ST_RISE     = 4'h1;
    localparam [3:0] ST_HOLD_TOP = 4'h2;
    localparam [3:0] ST_FALL     = 4'h4;
    localparam [3:0] ST_HOLD_BOT = 4'h8;

    // software-visible registers (holding copies for limits, delay, step, interval)
    reg [31:0] cfg_reg;
    reg [31:0] lim_hold_reg;
    reg [31:0] dly_hold_reg;
    reg [31:0] ramp_increment_reg;
    reg [31:0] ramp_interval_reg;

    // working copies used by the engine
    reg [7:0]  min_reg;
    reg [7:0]  max_reg;
    reg [11:0] bottom_hold_or_prescale;
    reg [11:0] top_hold_ticks;
    reg [31:0] ramp_increment_fields;
    reg [31:0] ramp_interval_fields;

    // engine state
    reg [7:0]  duty_reg;
    reg [11:0] dly_cnt_reg;
    reg [3:0]  state_reg;

    // bus slave state
    reg        aw_got_reg;
    reg        w_got_reg;
    reg [7:0]  waddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0]  wstrb_reg;

    wire [7:0] cycle_position_counter;
    wire       period_end;

    // byte-lane merge of a write into a register
    function [31:0] merge_bytes;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0]  strb;
        integer i;
        begin
            merge_bytes = old_val;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge_bytes[i*8 +: 8] = new_val[i*8 +: 8];
                end
            end
        end
    endfunction

    // 4-bit field of segment k from a step or interval word
    function [3:0] nibble_at;
        input [31:0] word;
        input [2:0]  k;
        begin
            nibble_at = word[{k, 2'b00} +: 4];
        end
    endfunction

    // segment index from duty, symmetry selection and ramp direction
    function [2:0] seg_index;
        input [7:0] duty;
        input       asym;
        input       falling;
        begin
            if (asym) begin
                seg_index = {falling, duty[7:6]};
            end else begin
                seg_index = duty[7:5];
            end
        end
    endfunction

    // duty scaled down to the selected counter width
    function [7:0] scaled_duty;
        input [7:0] duty;
        input [1:0] size;
        begin
            case (size)
                `SIZE_7: scaled_duty = {1'b0, duty[7:1]};
                `SIZE_6: scaled_duty = {2'b00, duty[7:2]};
                default: scaled_duty = duty;
            endcase
        end
    endfunction

    // address is one of the implemented words
    function known_addr;
        input [7:0] a;
        begin
            case ({a[7:2], 2'b00})
                `OFS_CFG, `OFS_LIMITS, `OFS_DELAY, `OFS_STEP,
                `OFS_INT, `OFS_OUTDLY, `OFS_STATUS: known_addr = 1'b1;
                default: known_addr = 1'b0;
            endcase
        end
    endfunction

    // mode decode
    wire [1:0] ctrl      = cfg_reg[`CFG_CTRL];
    wire       breathing = (ctrl == `CTRL_BREATH);
    wire       blinking  = (ctrl == `CTRL_BLINK) || (ctrl == `CTRL_ON);
    wire       asym      = cfg_reg[`CFG_SYM];

    // write path handshake: address and data taken in either order
    wire       do_write  = aw_got_reg && w_got_reg && !s_axi_bvalid;
    wire [7:0] waddr_wd  = {waddr_reg[7:2], 2'b00};
    wire       soft_clr  = do_write && (waddr_wd == `OFS_CFG) && wstrb_reg[0] && wdata_reg[`CFG_RESET];
    wire       clear_all = (ctrl == `CTRL_OFF) || soft_clr;

    assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_got_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // blink prescaler input: every system clock or the slow tick
    wire       blink_tick = blinking && (cfg_reg[`CFG_CLKSRC] || slow_tick);
    // breathing advances the counter on each slow tick; blinking on delay counter zero, so zero prescale passes every tick
    wire       pwm_adv    = breathing ? slow_tick : (blink_tick && (dly_cnt_reg == `CNT_RST));
    // blinking always runs the full 8-bit counter
    wire [1:0] eff_size   = breathing ? cfg_reg[`CFG_SIZE] : `SIZE_8;

    cycle_position_counter u_period (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .clear     (clear_all),
        .advance   (pwm_adv),
        .size_sel  (eff_size),
        .count_reg (cycle_position_counter),
        .wrap      (period_end)
    );

    // current segment step and interval
    wire [2:0] seg   = seg_index(duty_reg, asym, state_reg == ST_FALL);
    wire [3:0] stp   = nibble_at(ramp_increment_fields, seg);
    wire [3:0] itv   = nibble_at(ramp_interval_fields, seg);
    wire [8:0] up    = {1'b0, duty_reg} + {5'h00, stp};
    wire [8:0] floor = {1'b0, min_reg} + {5'h00, stp};
    wire       dly_due = (dly_cnt_reg <= `CNT_ONE);

    // bus write channel capture and register writes
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg         <= 1'b0;
            w_got_reg          <= 1'b0;
            waddr_reg          <= `BYTE_RST;
            wdata_reg          <= `REG_RST;
            wstrb_reg          <= 4'h0;
            s_axi_bvalid       <= 1'b0;
            s_axi_bresp        <= `RESP_OKAY;
            cfg_reg            <= `REG_RST;
            lim_hold_reg       <= `REG_RST;
            dly_hold_reg       <= `REG_RST;
            ramp_increment_reg <= `REG_RST;
            ramp_interval_reg  <= `REG_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg <= 1'b1;
                waddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_got_reg   <= 1'b0;
                w_got_reg    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= known_addr(waddr_reg) ? `RESP_OKAY : `RESP_SLVERR;
                // config acts at once; reset bit is a strobe and is not stored
                case (waddr_wd)
                    `OFS_CFG:    cfg_reg <= merge_bytes(cfg_reg, wdata_reg, wstrb_reg) & `CFG_WMASK;
                    `OFS_LIMITS: lim_hold_reg <= merge_bytes(lim_hold_reg, wdata_reg, wstrb_reg);
                    `OFS_DELAY:  dly_hold_reg <= merge_bytes(dly_hold_reg, wdata_reg, wstrb_reg);
                    `OFS_STEP:   ramp_increment_reg <= merge_bytes(ramp_increment_reg, wdata_reg, wstrb_reg);
                    `OFS_INT:    ramp_interval_reg <= merge_bytes(ramp_interval_reg, wdata_reg, wstrb_reg);
                    default:     ;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // bus read channel: answer one cycle after the address is taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= `REG_RST;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= known_addr(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            case ({s_axi_araddr[7:2], 2'b00})
                `OFS_CFG:    s_axi_rdata <= cfg_reg;
                `OFS_LIMITS: s_axi_rdata <= lim_hold_reg;
                `OFS_DELAY:  s_axi_rdata <= dly_hold_reg;
                `OFS_STEP:   s_axi_rdata <= ramp_increment_reg;
                `OFS_INT:    s_axi_rdata <= ramp_interval_reg;
                `OFS_STATUS: s_axi_rdata <= {8'h00, cycle_position_counter, 4'h0, state_reg, duty_reg};
                default:     s_axi_rdata <= `REG_RST;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // holding copies move to working copies only at a period boundary,
    // so a byte-at-a-time update made within one period never shows a half-written setting
    always @(posedge aclk) begin
        if (!aresetn || clear_all) begin
            min_reg                 <= `BYTE_RST;
            max_reg                 <= `BYTE_RST;
            bottom_hold_or_prescale <= `CNT_RST;
            top_hold_ticks          <= `CNT_RST;
            ramp_increment_fields   <= `REG_RST;
            ramp_interval_fields    <= `REG_RST;
        end else if (period_end) begin
            min_reg <= lim_hold_reg[`LIM_MIN];
            max_reg <= lim_hold_reg[`LIM_MAX];
            if (cfg_reg[`CFG_UPDEN]) begin
                bottom_hold_or_prescale <= dly_hold_reg[`DLY_LD];
                top_hold_ticks          <= dly_hold_reg[`DLY_HD];
                ramp_increment_fields   <= ramp_increment_reg;
                ramp_interval_fields    <= ramp_interval_reg;
            end
        end
    end

    // duty engine: blink prescaler, or breathing ramp paced by period ends
    always @(posedge aclk) begin
        if (!aresetn || clear_all) begin
            duty_reg    <= `BYTE_RST;
            dly_cnt_reg <= `CNT_RST;
            state_reg   <= ST_RISE;
        end else if (blinking) begin
            // duty is the lower limit; breathing fields are not consulted
            duty_reg <= min_reg;
            if (blink_tick) begin
                dly_cnt_reg <= (dly_cnt_reg == `CNT_RST) ? bottom_hold_or_prescale
                                                          : dly_cnt_reg - `CNT_ONE;
            end
        end else if (breathing && period_end) begin
            case (state_reg)
                ST_RISE: begin
                    if (dly_due) begin
                        dly_cnt_reg <= {8'h00, itv};
                        if (up >= {1'b0, max_reg}) begin
                            duty_reg    <= max_reg;
                            state_reg   <= ST_HOLD_TOP;
                            dly_cnt_reg <= top_hold_ticks;
                        end else begin
                            duty_reg <= up[7:0];
                        end
                    end else begin
                        dly_cnt_reg <= dly_cnt_reg - `CNT_ONE;
                    end
                end
                ST_HOLD_TOP: begin
                    if (dly_due) begin
                        state_reg   <= ST_FALL;
                        dly_cnt_reg <= `CNT_RST;
                    end else begin
                        dly_cnt_reg <= dly_cnt_reg - `CNT_ONE;
                    end
                end
                ST_FALL: begin
                    if (dly_due) begin
                        dly_cnt_reg <= {8'h00, itv};
                        if ({1'b0, duty_reg} <= floor) begin
                            duty_reg    <= min_reg;
                            state_reg   <= ST_HOLD_BOT;
                            dly_cnt_reg <= bottom_hold_or_prescale;
                        end else begin
                            duty_reg <= duty_reg - {4'h0, stp};
                        end
                    end else begin
                        dly_cnt_reg <= dly_cnt_reg - `CNT_ONE;
                    end
                end
                ST_HOLD_BOT: begin
                    if (dly_due) begin
                        state_reg   <= ST_RISE;
                        dly_cnt_reg <= `CNT_RST;
                    end else begin
                        dly_cnt_reg <= dly_cnt_reg - `CNT_ONE;
                    end
                end
                default: begin
                    state_reg <= ST_RISE;
                end
            endcase
        end
    end

    // registered led output; one cycle behind the counter, which only adds a fixed skew
    always @(posedge aclk) begin
        if (!aresetn || clear_all) begin
            led_out <= 1'b0;
        end else if (ctrl == `CTRL_ON) begin
            led_out <= 1'b1;
        end else if (blinking) begin
            led_out <= (min_reg == `TOP_8) || (cycle_position_counter < min_reg);
        end else begin
            led_out <= (cycle_position_counter < scaled_duty(duty_reg, eff_size));
        end
    end

endmodule

/* led_pwm_map.vh */
// register map, field positions and codes for the led breathing/blinking pwm
`ifndef LED_PWM_MAP_VH
`define LED_PWM_MAP_VH

// register byte offsets
`define OFS_CFG      8'h00
`define OFS_LIMITS   8'h04
`define OFS_DELAY    8'h08
`define OFS_STEP     8'h0C
`define OFS_INT      8'h10
`define OFS_OUTDLY   8'h14
`define OFS_STATUS   8'h18

// configuration register fields
`define CFG_CTRL     1:0
`define CFG_CLKSRC   2
`define CFG_UPDEN    3
`define CFG_SIZE     5:4
`define CFG_RESET    7
`define CFG_SYM      16
`define CFG_WMASK    32'h0001003F

// limits and delay register fields
`define LIM_MIN      7:0
`define LIM_MAX      15:8
`define DLY_LD       11:0
`define DLY_HD       23:12

// reset values
`define REG_RST      32'h00000000
`define BYTE_RST     8'h00
`define CNT_RST      12'h000
`define CNT_ONE      12'h001

// output control codes
`define CTRL_OFF     2'h0
`define CTRL_BREATH  2'h1
`define CTRL_BLINK   2'h2
`define CTRL_ON      2'h3

// pwm size codes and counter tops
`define SIZE_8       2'h0
`define SIZE_7       2'h1
`define SIZE_6       2'h2
`define TOP_8        8'hFF
`define TOP_7        8'h7F
`define TOP_6        8'h3F

// bus response codes
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

`endif

/* cycle_position_counter.v */
// pwm period counter with selectable 8, 7 or 6 bit wrap point
`timescale 1ns/1ps
`include "led_pwm_map.vh"

module cycle_position_counter (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       clear,
    input  wire       advance,
    input  wire [1:0] size_sel,
    output reg  [7:0] count_reg,
    output wire       wrap
);

    reg [7:0] top;

    // wrap point follows the size selection
    always @* begin
        case (size_sel)
            `SIZE_7: top = `TOP_7;
            `SIZE_6: top = `TOP_6;
            default: top = `TOP_8;
        endcase
    end

    // end of period: counter leaves its top value
    assign wrap = advance && (count_reg >= top);

    // count ticks and wrap continuously; a size change that puts the top below the count also wraps
    always @(posedge aclk) begin
        if (!aresetn || clear) begin
            count_reg <= `BYTE_RST;
        end else if (wrap) begin
            count_reg <= `BYTE_RST;
        end else if (advance) begin
            count_reg <= count_reg + 8'h01;
        end
    end

endmodule

/* led_load.sv */
// led load model: integrates how long the led is lit
`timescale 1ns/1ps

module led_load (
    input  wire aclk,
    input  wire led_in,
    input  wire clr,
    output int  lit_count
);
    // a plain led has no handshake; brightness is the lit time, so count it
    always @(posedge aclk) begin
        if (clr) begin
            lit_count <= 0;
        end else if (led_in === 1'b1) begin
            lit_count <= lit_count + 1;
        end
    end
endmodule

/* led_breathing_blinking_pwm_checker.sv */
// bus and reset assertions on the led pwm ports
`timescale 1ns/1ps

module led_pwm_checker (
    input wire        aclk,
    input wire        aresetn,
    input wire        slow_tick,
    input wire [7:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0]  s_axi_wstrb,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        led_out
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // read side: fixed one-cycle answer, held until taken, single outstanding
    chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_read_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h1C
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer dropped");
    chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    chk_read_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answered twice");
    // write side: response follows both channels and blocks new requests
    chk_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    chk_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    chk_reset_clear: assert property (disable iff (1'b0) !aresetn |=> !led_out && !s_axi_bvalid && !s_axi_rvalid)
        else $error("reset left outputs active");
endmodule

bind led_breathing_blinking_pwm led_pwm_checker chk (
    .aclk(aclk), .aresetn(aresetn), .slow_tick(slow_tick), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .led_out(led_out));

/* led_breathing_blinking_pwm_bench.sv */
// self-checking bench for the led breathing/blinking pwm
`timescale 1ns/1ps

module led_breathing_blinking_pwm_bench;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        slow_tick = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready = 1'b0;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready = 1'b0;
    logic        led_out;
    logic        clr = 1'b0;
    int          lit_count;
    int          fail_count = 0;
    int          comparisons = 0;
    int          cycles = 0;

    led_breathing_blinking_pwm dut (.aclk(aclk), .aresetn(aresetn), .slow_tick(slow_tick),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .led_out(led_out));
    led_load load (.aclk(aclk), .led_in(led_out), .clr(clr), .lit_count(lit_count));

    // 125 MHz clock; slow tick pulses every other cycle so long periods stay short
    always #4 aclk = ~aclk;
    always @(posedge aclk) begin
        slow_tick <= ~slow_tick;
    end

    // hang guard: ceiling well above the ~14k cycles the scenarios need
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fail_count++;
            test_done;
        end
    end

    task check(input logic [31:0] got, input logic [31:0] exp);
        begin
            comparisons++;
            if (got !== exp) begin
                fail_count++;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task test_done;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, fail_count);
            if (fail_count == 0 && comparisons > 0) begin
                $display("*** PASS ***");
            end else begin
                $display("*** FAIL ***");
            end
            $finish;
        end
    endtask

    // both channels offered together, each dropped at its own handshake
    task axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        bit aw_ok;
        bit w_ok;
        begin
            aw_ok = 0;
            w_ok = 0;
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_wstrb <= s;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            while (!(aw_ok && w_ok)) begin
                @(posedge aclk);
                if (s_axi_awvalid && s_axi_awready === 1'b1) begin
                    aw_ok = 1;
                    s_axi_awvalid <= 1'b0;
                end
                if (s_axi_wvalid && s_axi_wready === 1'b1) begin
                    w_ok = 1;
                    s_axi_wvalid <= 1'b0;
                end
            end
            while (s_axi_bvalid !== 1'b1) @(posedge aclk);
            s_axi_bready <= 1'b0;
            check({30'h0, s_axi_bresp}, {30'h0, er});
            @(posedge aclk);
        end
    endtask

    task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            do @(posedge aclk); while (s_axi_arready !== 1'b1);
            s_axi_arvalid <= 1'b0;
            do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            @(posedge aclk);
        end
    endtask

    // reset values, readback, write-only and reserved bits, byte lanes, unmapped space
    task reg_test;
        logic [31:0] d;
        logic [1:0]  r;
        int          a;
        begin
            for (a = 0; a <= 24; a += 4) begin
                axi_read(a[7:0], d, r);
                check(d, (a == 24) ? 32'h100 : 32'h0);
            end
            axi_write(8'h0C, 32'h12345678, 4'hF, 2'h0);
            axi_read(8'h0C, d, r);
            check(d, 32'h12345678);
            axi_write(8'h10, 32'h9ABCDEF0, 4'hF, 2'h0);
            axi_read(8'h10, d, r);
            check(d, 32'h9ABCDEF0);
            axi_write(8'h00, 32'hFFFFFFFF, 4'hF, 2'h0);
            axi_read(8'h00, d, r);
            check(d, 32'h0001003F);
            axi_write(8'h00, 32'h0, 4'hF, 2'h0);
            axi_write(8'h04, 32'h0000CCDD, 4'h2, 2'h0);
            axi_read(8'h04, d, r);
            check(d, 32'h0000CC00);
            axi_write(8'h40, 32'h1, 4'hF, 2'h2);
            axi_read(8'h40, d, r);
            check({d[31:2], r}, 32'h2);
        end
    endtask

    // blink/pwm: measure lit cycles over exactly one period once settled
    task blink_one(input logic [31:0] cf, input logic [7:0] mn, input logic [11:0] ld, input int win, input int ex);
        begin
            axi_write(8'h08, {20'h0, ld}, 4'hF, 2'h0);
            axi_write(8'h04, {16'h00FF, mn}, 4'hF, 2'h0);
            axi_write(8'h00, cf, 4'hF, 2'h0);
            repeat (win + 600) @(posedge aclk);
            clr <= 1'b1;
            @(posedge aclk);
            clr <= 1'b0;
            repeat (win) @(posedge aclk);
            #1;
            check(lit_count, ex);
            @(posedge aclk);
        end
    endtask

    // breathing, 6-bit: steps 15 then 5 rising, 10/5/15 falling, clamped at 0x40 and 0
    task breathe;
        logic [31:0] d;
        logic [1:0]  r;
        logic [7:0]  duty;
        logic [7:0]  top_cnt;
        bit          saw_top;
        bit          saw_low;
        bit          bad;
        int          i;
        begin
            saw_top = 0;
            saw_low = 0;
            bad = 0;
            top_cnt = 8'h00;
            axi_write(8'h00, 32'h0, 4'hF, 2'h0);
            axi_write(8'h04, 32'h00004000, 4'hF, 2'h0);
            axi_write(8'h08, 32'h00001001, 4'hF, 2'h0);
            axi_write(8'h0C, 32'h00000A5F, 4'hF, 2'h0);
            axi_write(8'h10, 32'h11111111, 4'hF, 2'h0);
            axi_write(8'h00, 32'h21, 4'hF, 2'h0);
            repeat (800) @(posedge aclk);
            axi_read(8'h18, d, r);
            check({24'h0, d[7:0]}, 32'h0);
            axi_write(8'h00, 32'h29, 4'hF, 2'h0);
            for (i = 0; i < 300; i++) begin
                axi_read(8'h18, d, r);
                duty = d[7:0];
                if (d[23:16] > top_cnt) top_cnt = d[23:16];
                if (!(duty inside {8'h00, 8'h0F, 8'h1E, 8'h2D, 8'h32, 8'h37, 8'h3C, 8'h40,
                                   8'h36, 8'h31, 8'h2C, 8'h27, 8'h22, 8'h1D, 8'h0E})) bad = 1;
                if (d[11:8] == 4'h2 && duty == 8'h40) saw_top = 1;
                if (d[11:8] == 4'h8 && duty == 8'h00 && saw_top) saw_low = 1;
                repeat (7) @(posedge aclk);
            end
            check({31'h0, bad}, 32'h0);
            check({31'h0, saw_top}, 32'h1);
            check({31'h0, saw_low}, 32'h1);
            check({31'h0, (top_cnt <= 8'h3F && top_cnt >= 8'h30)}, 32'h1);
        end
    endtask

    // main sequence; step/interval stay nonzero during blink to show they are ignored
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        reg_test;
        blink_one(32'h0E, 8'h40, 12'h000, 256, 64);
        blink_one(32'h1E, 8'h40, 12'h000, 256, 64);
        blink_one(32'h2E, 8'h40, 12'h001, 512, 128);
        blink_one(32'h0A, 8'h40, 12'h000, 512, 128);
        blink_one(32'h0E, 8'h00, 12'h000, 256, 0);
        blink_one(32'h0E, 8'hFF, 12'h000, 256, 256);
        blink_one(32'h0F, 8'h10, 12'h000, 256, 256);
        blink_one(32'h00, 8'h40, 12'h000, 256, 0);
        breathe;
        test_done;
    end
endmodule
